// *** hw/cpu_ctrl_pkg.sv ***
// Constants for the CPU control-state block: memory map, vectors, status word, bus map.
// Assumes a 16-bit address space and a 32-bit AHB-Lite register bus.
package cpu_ctrl_pkg;
  // Memory map
  localparam logic [15:0] VEC_BASE     = 16'h0000;
  localparam logic [15:0] VEC_LAST     = 16'h0019;
  localparam logic [15:0] VEC_RESET    = 16'h0000;
  localparam logic [15:0] VEC_IRQ_BASE = 16'h0004;
  localparam logic [15:0] VEC_IRQ_LAST = 16'h0018;
  localparam logic [15:0] TBL_BASE     = 16'h0040;
  localparam logic [15:0] TBL_LAST     = 16'h007F;
  localparam logic [15:0] RAM_BASE     = 16'hFE00;
  localparam logic [15:0] RAM_LAST     = 16'hFEFF;
  localparam logic [15:0] SFR_BASE     = 16'hFF00;
  localparam logic [15:0] SFR_LAST     = 16'hFFFF;
  localparam int          NUM_IRQ      = 11;
  // Status word
  localparam logic [7:0]  STATUS_RESET = 8'h02;
  localparam int          BIT_CY       = 0;
  localparam int          BIT_FIX1     = 1;
  localparam int          BIT_AC       = 4;
  localparam int          BIT_Z        = 6;
  localparam int          BIT_IE       = 7;
  // Register byte addresses
  localparam logic [7:0]  REG_PC       = 8'h00;
  localparam logic [7:0]  REG_STATUS   = 8'h04;
  localparam logic [7:0]  REG_SP       = 8'h08;
  localparam logic [7:0]  REG_CMD      = 8'h0C;
  localparam logic [7:0]  REG_OPND     = 8'h10;
  localparam logic [7:0]  REG_IRQ      = 8'h14;
  localparam logic [7:0]  REG_MASK     = 8'h18;
  localparam logic [7:0]  REG_ACCESS   = 8'h1C;
  localparam logic [7:0]  REG_RESULT   = 8'h20;
  // Commands written to REG_CMD
  localparam logic [3:0]  CMD_ADVANCE  = 4'h1;
  localparam logic [3:0]  CMD_BRANCH   = 4'h2;
  localparam logic [3:0]  CMD_TCALL    = 4'h3;
  localparam logic [3:0]  CMD_PUSH_ST  = 4'h4;
  localparam logic [3:0]  CMD_POP_ST   = 4'h5;
  localparam logic [3:0]  CMD_RETURN_FROM_IRQ_INSTRUCTION     = 4'h6;
  localparam logic [3:0]  CMD_DI       = 4'h7;
  localparam logic [3:0]  CMD_EI       = 4'h8;
  localparam logic [3:0]  CMD_ADD      = 4'h9;
  localparam logic [3:0]  CMD_SUB      = 4'hA;
  localparam logic [3:0]  CMD_ROTL     = 4'hB;
  localparam logic [3:0]  CMD_SETCY    = 4'hC;
  localparam logic [3:0]  CMD_ANDCY    = 4'hD;
  localparam logic [3:0]  CMD_ORCY     = 4'hE;
  // Region codes
  localparam logic [2:0]  RGN_VEC      = 3'h1;
  localparam logic [2:0]  RGN_TBL      = 3'h2;
  localparam logic [2:0]  RGN_RAM      = 3'h3;
  localparam logic [2:0]  RGN_SFR      = 3'h4;
  localparam logic [2:0]  RGN_PROG     = 3'h0;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
endpackage : cpu_ctrl_pkg

// *** hw/region_decode.sv ***
// Address map decoder: classifies a 16-bit address into its region.
// Assumes purely combinational use in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module region_decode (
  // Address in
  input  wire logic [15:0] addr,
  // Region out
  output logic      [2:0]  region
);
  always_comb begin
    if (addr >= cpu_ctrl_pkg::SFR_BASE) begin
      region = cpu_ctrl_pkg::RGN_SFR;
    end else if (addr >= cpu_ctrl_pkg::RAM_BASE && addr <= cpu_ctrl_pkg::RAM_LAST) begin
      region = cpu_ctrl_pkg::RGN_RAM;
    end else if (addr >= cpu_ctrl_pkg::TBL_BASE && addr <= cpu_ctrl_pkg::TBL_LAST) begin
      region = cpu_ctrl_pkg::RGN_TBL;
    end else if (addr <= cpu_ctrl_pkg::VEC_LAST) begin
      region = cpu_ctrl_pkg::RGN_VEC;
    end else begin
      region = cpu_ctrl_pkg::RGN_PROG;
    end
  end
endmodule : region_decode
`default_nettype wire

// *** hw/cpu_ctrl.sv ***
// CPU control state: program counter, status word, stack pointer, stack RAM.
// Assumes one AHB-Lite master; hclk at 250 MHz; memory read by word-less byte ports.
// Operation
// - Flat 64 KB space addressed with 16-bit addresses.
// - Vector area 0000H-0019H, low byte even, high byte odd.
// - Reset and interrupts branch through their vector entries.
// - Table call reads its entry from 0040H-007FH.
// - RAM at FE00H-FEFFH also serves as stack.
// - Peripheral registers decoded at FF00H-FFFFH.
// - PC advances by instruction length, branches load new value.
// - Reset loads PC from bytes at 0000H and 0001H.
// - Status word pushed on interrupt or push, popped by return_from_irq_instruction/pop.
// - Reset sets the status word to 02H.
// - Interrupts refused when enable flag clear, else gated by masks.
// - Enable flag cleared by disable and acknowledge, set by enable.
// - Zero flag set on zero result, else cleared; here only add and sub update it, rotate leaves it unchanged.
// - Half-carry flag tracks carry or borrow at bit 3.
// - Carry records add/sub overflow, rotate shift-out, bit accumulator.
// - Stack pointer holds stack start, confined to internal RAM; here pushes outside it are dropped and set a sticky flag.
// - Pre-decrement before save, post-increment after restore.
// - Stack pointer undefined after reset, software must load it; reset here clears it to 0000H.
`timescale 1ns/1ns
`default_nettype none
module cpu_ctrl (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Program memory byte read port
  output logic      [15:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  // Peripheral window select
  output logic             sfr_sel
);
  localparam int NUM_IRQ_W = cpu_ctrl_pkg::NUM_IRQ;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'd0,
    ST_VEC_LO  = 3'd1,
    ST_VEC_HI  = 3'd2,
    ST_PUSH_HI = 3'd3,
    ST_PUSH_LO = 3'd4,
    ST_PUSH_ST = 3'd5,
    ST_POP     = 3'd6
  } seq_t;

  typedef struct packed {
    seq_t        seq;
    logic [15:0] pc;
    logic [7:0]  status;
    logic [15:0] sp;
    logic [15:0] opnd;
    logic [15:0] vec_addr;
    logic [15:0] new_pc;
    logic [1:0]  pop_left;
    logic        pop_return_from_irq_instruction;
    logic [NUM_IRQ_W-1:0] irq_pend;
    logic [NUM_IRQ_W-1:0] irq_mask;
    logic [15:0] access_addr;
    logic [7:0]  result;
    logic        dp_act;
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    logic        bad_sp;
    logic        irq_frame;
  } state_t;

  state_t      cur_ff;
  state_t      nxt_st;
  logic [7:0]  ram [256];
  logic        ram_we;
  logic [7:0]  ram_wa;
  logic [7:0]  ram_wd;
  logic [2:0]  acc_region;
  logic [3:0]  cmd;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [7:0]  res8;

  region_decode u_decode (
    .addr   (cur_ff.access_addr),
    .region (acc_region)
  );

  // Lowest set pending-and-unmasked source wins
  function automatic logic [3:0] pick_irq(input logic [NUM_IRQ_W-1:0] req);
    logic [3:0] idx;
    idx = 4'hF;
    for (int i = NUM_IRQ_W - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : pick_irq

  function automatic logic in_ram(input logic [15:0] a);
    return (a >= cpu_ctrl_pkg::RAM_BASE) && (a <= cpu_ctrl_pkg::RAM_LAST);
  endfunction : in_ram

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = cur_ff.rdata;
  assign sfr_sel   = (acc_region == cpu_ctrl_pkg::RGN_SFR);
  assign cmd       = hwdata[3:0];

  always_comb begin
    logic [3:0]  irq_idx;
    logic        take;
    logic [7:0]  a8;
    logic [7:0]  b8;
    irq_idx  = pick_irq(cur_ff.irq_pend & cur_ff.irq_mask);
    take     = 1'b0;
    a8       = cur_ff.opnd[7:0];
    b8       = cur_ff.opnd[15:8];
    nxt_st   = cur_ff;
    ram_we   = 1'b0;
    ram_wa   = 8'h00;
    ram_wd   = 8'h00;
    mem_addr = cur_ff.vec_addr;
    sum9     = 9'h000;
    sum5     = 5'h00;
    res8     = 8'h00;
    nxt_st.dp_act = 1'b0;
    if (hsel && hready && htrans == cpu_ctrl_pkg::HTRANS_NSEQ) begin
      nxt_st.dp_act  = 1'b1;
      nxt_st.dp_wr   = hwrite;
      nxt_st.dp_addr = haddr[7:0];
    end
    unique case (cur_ff.seq)
      ST_IDLE: begin
        // Interrupts only accepted when enable flag is set and mask allows
        if (cur_ff.status[cpu_ctrl_pkg::BIT_IE] && irq_idx != 4'hF) begin
          take = 1'b1;
          nxt_st.irq_pend[irq_idx] = 1'b0;
          nxt_st.vec_addr = cpu_ctrl_pkg::VEC_IRQ_BASE + 16'({irq_idx, 1'b0});
          nxt_st.status[cpu_ctrl_pkg::BIT_IE] = 1'b0;
          nxt_st.irq_frame = 1'b1;
          nxt_st.seq = ST_PUSH_HI;
        end
      end
      ST_VEC_LO: begin
        nxt_st.new_pc[7:0] = mem_rdata;
        nxt_st.vec_addr = cur_ff.vec_addr + 16'h0001;
        nxt_st.seq = ST_VEC_HI;
      end
      ST_VEC_HI: begin
        nxt_st.pc = {mem_rdata, cur_ff.new_pc[7:0]};
        nxt_st.seq = ST_IDLE;
      end
      ST_PUSH_HI, ST_PUSH_LO, ST_PUSH_ST: begin
        // Save order: status, PC high, PC low, each after a decrement
        nxt_st.sp = cur_ff.sp - 16'h0001;
        ram_we = in_ram(nxt_st.sp);
        nxt_st.bad_sp = cur_ff.bad_sp | ~in_ram(nxt_st.sp);
        ram_wa = nxt_st.sp[7:0];
        if (cur_ff.seq == ST_PUSH_HI) begin
          // Frame keeps the enable flag as it stood before the acknowledge
          ram_wd = cur_ff.status;
          ram_wd[cpu_ctrl_pkg::BIT_IE] = cur_ff.status[cpu_ctrl_pkg::BIT_IE] | cur_ff.irq_frame;
          nxt_st.seq = ST_PUSH_LO;
        end else if (cur_ff.seq == ST_PUSH_LO) begin
          ram_wd = cur_ff.pc[15:8];
          nxt_st.seq = ST_PUSH_ST;
        end else begin
          ram_wd = cur_ff.pc[7:0];
          nxt_st.seq = ST_VEC_LO;
        end
      end
      ST_POP: begin
        // Restore reads at sp then increments
        if (cur_ff.pop_return_from_irq_instruction && cur_ff.pop_left == 2'd3) begin
          nxt_st.pc[7:0] = ram[cur_ff.sp[7:0]];
        end else if (cur_ff.pop_return_from_irq_instruction && cur_ff.pop_left == 2'd2) begin
          nxt_st.pc[15:8] = ram[cur_ff.sp[7:0]];
        end else begin
          nxt_st.status = ram[cur_ff.sp[7:0]];
        end
        nxt_st.sp = cur_ff.sp + 16'h0001;
        nxt_st.pop_left = cur_ff.pop_left - 2'd1;
        if (cur_ff.pop_left == 2'd1) begin
          nxt_st.seq = ST_IDLE;
        end
      end
      default: nxt_st.seq = ST_IDLE;
    endcase
    // Register writes in the data phase; all but REG_IRQ ignored while a sequence runs
    if (cur_ff.dp_act && cur_ff.dp_wr && cur_ff.seq == ST_IDLE && !take) begin
      unique case (cur_ff.dp_addr)
        cpu_ctrl_pkg::REG_STATUS: nxt_st.status = hwdata[7:0];
        cpu_ctrl_pkg::REG_SP:     nxt_st.sp = hwdata[15:0];
        cpu_ctrl_pkg::REG_OPND:   nxt_st.opnd = hwdata[15:0];
        cpu_ctrl_pkg::REG_MASK:   nxt_st.irq_mask = hwdata[NUM_IRQ_W-1:0];
        cpu_ctrl_pkg::REG_ACCESS: nxt_st.access_addr = hwdata[15:0];
        cpu_ctrl_pkg::REG_CMD: begin
          unique case (cmd)
            cpu_ctrl_pkg::CMD_ADVANCE: nxt_st.pc = cur_ff.pc + 16'(hwdata[6:4]);
            cpu_ctrl_pkg::CMD_BRANCH:  nxt_st.pc = cur_ff.opnd;
            cpu_ctrl_pkg::CMD_TCALL: begin
              nxt_st.vec_addr = cpu_ctrl_pkg::TBL_BASE + 16'({hwdata[8:4], 1'b0});
              nxt_st.seq = ST_VEC_LO;
            end
            cpu_ctrl_pkg::CMD_PUSH_ST: begin
              nxt_st.irq_frame = 1'b0;
              nxt_st.seq = ST_PUSH_HI;
              nxt_st.vec_addr = cur_ff.pc;
            end
            cpu_ctrl_pkg::CMD_POP_ST: begin
              nxt_st.pop_return_from_irq_instruction = 1'b0;
              nxt_st.pop_left = 2'd1;
              nxt_st.seq = ST_POP;
            end
            cpu_ctrl_pkg::CMD_RETURN_FROM_IRQ_INSTRUCTION: begin
              nxt_st.pop_return_from_irq_instruction = 1'b1;
              nxt_st.pop_left = 2'd3;
              nxt_st.seq = ST_POP;
            end
            cpu_ctrl_pkg::CMD_DI: nxt_st.status[cpu_ctrl_pkg::BIT_IE] = 1'b0;
            cpu_ctrl_pkg::CMD_EI: nxt_st.status[cpu_ctrl_pkg::BIT_IE] = 1'b1;
            cpu_ctrl_pkg::CMD_ADD: begin
              sum9 = {1'b0, a8} + {1'b0, b8};
              sum5 = {1'b0, a8[3:0]} + {1'b0, b8[3:0]};
              res8 = sum9[7:0];
              nxt_st.result = res8;
              nxt_st.status[cpu_ctrl_pkg::BIT_CY] = sum9[8];
              nxt_st.status[cpu_ctrl_pkg::BIT_AC] = sum5[4];
              nxt_st.status[cpu_ctrl_pkg::BIT_Z]  = (res8 == 8'h00);
            end
            cpu_ctrl_pkg::CMD_SUB: begin
              sum9 = {1'b0, a8} - {1'b0, b8};
              sum5 = {1'b0, a8[3:0]} - {1'b0, b8[3:0]};
              res8 = sum9[7:0];
              nxt_st.result = res8;
              nxt_st.status[cpu_ctrl_pkg::BIT_CY] = sum9[8];
              nxt_st.status[cpu_ctrl_pkg::BIT_AC] = sum5[4];
              nxt_st.status[cpu_ctrl_pkg::BIT_Z]  = (res8 == 8'h00);
            end
            cpu_ctrl_pkg::CMD_ROTL: begin
              nxt_st.result = {a8[6:0], a8[7]};
              nxt_st.status[cpu_ctrl_pkg::BIT_CY] = a8[7];
            end
            cpu_ctrl_pkg::CMD_SETCY: nxt_st.status[cpu_ctrl_pkg::BIT_CY] = hwdata[4];
            cpu_ctrl_pkg::CMD_ANDCY: nxt_st.status[cpu_ctrl_pkg::BIT_CY] =
                                       cur_ff.status[cpu_ctrl_pkg::BIT_CY] & hwdata[4];
            cpu_ctrl_pkg::CMD_ORCY:  nxt_st.status[cpu_ctrl_pkg::BIT_CY] =
                                       cur_ff.status[cpu_ctrl_pkg::BIT_CY] | hwdata[4];
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    // Requests raised in the same cycle as a clear still land
    if (cur_ff.dp_act && cur_ff.dp_wr && cur_ff.dp_addr == cpu_ctrl_pkg::REG_IRQ) begin
      nxt_st.irq_pend = nxt_st.irq_pend | hwdata[NUM_IRQ_W-1:0];
    end
    // Read data captured for the next data phase
    nxt_st.rdata = 32'h0000_0000;
    if (hsel && hready && htrans == cpu_ctrl_pkg::HTRANS_NSEQ && !hwrite) begin
      unique case (haddr[7:0])
        cpu_ctrl_pkg::REG_PC:     nxt_st.rdata = {16'h0000, nxt_st.pc};
        cpu_ctrl_pkg::REG_STATUS: nxt_st.rdata = {24'h000000, nxt_st.status};
        cpu_ctrl_pkg::REG_SP:     nxt_st.rdata = {15'h0000, nxt_st.bad_sp, nxt_st.sp};
        cpu_ctrl_pkg::REG_CMD:    nxt_st.rdata = {29'h0, nxt_st.seq};
        cpu_ctrl_pkg::REG_OPND:   nxt_st.rdata = {16'h0000, nxt_st.opnd};
        cpu_ctrl_pkg::REG_IRQ:    nxt_st.rdata = {21'h0, nxt_st.irq_pend};
        cpu_ctrl_pkg::REG_MASK:   nxt_st.rdata = {21'h0, nxt_st.irq_mask};
        cpu_ctrl_pkg::REG_ACCESS: nxt_st.rdata = {13'h0, acc_region, nxt_st.access_addr};
        cpu_ctrl_pkg::REG_RESULT: nxt_st.rdata = {24'h000000, nxt_st.result};
        default:                  nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff          <= '0;
      cur_ff.seq      <= ST_VEC_LO;
      cur_ff.vec_addr <= cpu_ctrl_pkg::VEC_RESET;
      cur_ff.status   <= cpu_ctrl_pkg::STATUS_RESET;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Stack RAM has no reset; contents undefined after power-up
  always_ff @(posedge hclk) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  a_status_reset: assert property (@(posedge hclk) $rose(hresetn) |->
    cur_ff.status == cpu_ctrl_pkg::STATUS_RESET) else $error("status not 02 after reset");
  a_flags_clear: assert property (@(posedge hclk) $rose(hresetn) |->
    !cur_ff.status[cpu_ctrl_pkg::BIT_IE] && !cur_ff.status[cpu_ctrl_pkg::BIT_Z]
    && !cur_ff.status[cpu_ctrl_pkg::BIT_AC]
    && !cur_ff.status[cpu_ctrl_pkg::BIT_CY]) else $error("flags set at reset");
  a_reset_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> mem_addr == cpu_ctrl_pkg::VEC_RESET ##1 mem_addr == 16'h0001)
    else $error("reset vector fetch wrong");
  a_ie_gates: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur_ff.seq == ST_IDLE && !cur_ff.status[cpu_ctrl_pkg::BIT_IE]) |=>
    (cur_ff.irq_pend & $past(cur_ff.irq_pend)) == $past(cur_ff.irq_pend))
    else $error("irq taken while disabled");
  a_ack_clears_ie: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur_ff.seq == ST_IDLE && cur_ff.status[cpu_ctrl_pkg::BIT_IE] && (cur_ff.irq_pend & cur_ff.irq_mask) != '0)
    |=> cur_ff.seq == ST_PUSH_HI && !cur_ff.status[cpu_ctrl_pkg::BIT_IE])
    else $error("ack left enable set");
  a_push_predec: assert property (@(posedge hclk) disable iff (!hresetn)
    cur_ff.seq == ST_PUSH_HI |=> cur_ff.sp == $past(cur_ff.sp) - 16'h0001
    ##1 cur_ff.sp == $past(cur_ff.sp, 2) - 16'h0002) else $error("push decrement wrong");
  a_pop_postinc: assert property (@(posedge hclk) disable iff (!hresetn)
    cur_ff.seq == ST_POP |=> cur_ff.sp == $past(cur_ff.sp) + 16'h0001)
    else $error("pop increment wrong");
  a_vec_to_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    cur_ff.seq == ST_VEC_LO |=> cur_ff.seq == ST_VEC_HI ##1 cur_ff.seq == ST_IDLE)
    else $error("vector load sequence wrong");
  a_zero_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur_ff.dp_act && cur_ff.dp_wr && cur_ff.dp_addr == cpu_ctrl_pkg::REG_CMD
     && cmd == cpu_ctrl_pkg::CMD_ADD && cur_ff.seq == ST_IDLE && nxt_st.seq == ST_IDLE)
    |=> cur_ff.status[cpu_ctrl_pkg::BIT_Z] == (cur_ff.result == 8'h00))
    else $error("zero flag mismatch");
  c_irq_taken: cover property (@(posedge hclk) disable iff (!hresetn)
    cur_ff.seq == ST_IDLE ##1 cur_ff.seq == ST_PUSH_HI);
  c_return_from_irq_instruction_done: cover property (@(posedge hclk) disable iff (!hresetn)
    cur_ff.seq == ST_POP && cur_ff.pop_return_from_irq_instruction ##3 cur_ff.seq == ST_IDLE);
  c_tcall: cover property (@(posedge hclk) disable iff (!hresetn)
    cur_ff.seq == ST_VEC_LO && cur_ff.vec_addr >= cpu_ctrl_pkg::TBL_BASE);
  c_push_cmd: cover property (@(posedge hclk) disable iff (!hresetn)
    cur_ff.seq == ST_PUSH_HI && !cur_ff.irq_frame);
  c_pend_refused: cover property (@(posedge hclk) disable iff (!hresetn)
    cur_ff.seq == ST_IDLE && !cur_ff.status[cpu_ctrl_pkg::BIT_IE] && cur_ff.irq_pend != '0);
endmodule : cpu_ctrl
`default_nettype wire

// *** verification/cpu_control_state_and_memory_map_tb.sv ***
// Testbench for the CPU control-state block: reset vector, counter, flags, stack, interrupts, address map.
// Assumes the block is the only AHB-Lite slave; a small byte pattern stands in for program memory.
`timescale 1ns/1ns
`default_nettype none
module cpu_control_state_and_memory_map_tb;
  typedef struct packed {
    logic [3:0] c;
    logic [4:0] arg;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r;
    logic [2:0] m;
    logic [2:0] f;
  } op_t;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] mem_addr;
  wire logic [7:0] mem_rdata;
  logic        sfr_sel;
  logic [31:0] rv;
  logic [15:0] pc_keep;
  int          err_total;
  int          tests_run;
  // Flags checked per op as {zero, half carry, carry}; carry chain ops depend on table order
  op_t ops [9] = '{
    '{cpu_ctrl_pkg::CMD_ADD, 5'h00, 8'h0F, 8'h01, 8'h10, 3'h7, 3'h2},
    '{cpu_ctrl_pkg::CMD_ADD, 5'h00, 8'h80, 8'h80, 8'h00, 3'h7, 3'h5},
    '{cpu_ctrl_pkg::CMD_SUB, 5'h00, 8'h10, 8'h01, 8'h0F, 3'h7, 3'h2},
    '{cpu_ctrl_pkg::CMD_SUB, 5'h00, 8'h00, 8'h01, 8'hFF, 3'h7, 3'h3},
    '{cpu_ctrl_pkg::CMD_SUB, 5'h00, 8'h05, 8'h05, 8'h00, 3'h7, 3'h4},
    '{cpu_ctrl_pkg::CMD_ROTL, 5'h00, 8'h80, 8'h00, 8'h00, 3'h1, 3'h1},
    '{cpu_ctrl_pkg::CMD_SETCY, 5'h01, 8'h00, 8'h00, 8'h00, 3'h1, 3'h1},
    '{cpu_ctrl_pkg::CMD_ANDCY, 5'h00, 8'h00, 8'h00, 8'h00, 3'h1, 3'h0},
    '{cpu_ctrl_pkg::CMD_ORCY, 5'h01, 8'h00, 8'h00, 8'h00, 3'h1, 3'h1}};
  // Address map probes: address, region code, peripheral select
  logic [15:0] rg_a [11] = '{16'h0000, 16'h0019, 16'h001A, 16'h0040, 16'h007F, 16'h0080,
                             16'hFDFF, 16'hFE00, 16'hFEFF, 16'hFF00, 16'hFFFF};
  logic [2:0]  rg_e [11] = '{3'h1, 3'h1, 3'h0, 3'h2, 3'h2, 3'h0, 3'h0, 3'h3, 3'h3, 3'h4, 3'h4};

  cpu_ctrl dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .mem_addr  (mem_addr),
    .mem_rdata (mem_rdata),
    .sfr_sel   (sfr_sel)
  );

  // Program memory pattern, distinct per address within a 256-byte page so a wrong byte shows
  function automatic logic [7:0] rom(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction : rom
  function automatic logic [15:0] vec(input logic [15:0] a);
    return {rom(a + 16'h0001), rom(a)};
  endfunction : vec

  assign mem_rdata = rom(mem_addr);
  assign hready    = hreadyout;

  always #2 hclk = ~hclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, g, e);
      err_total++;
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= cpu_ctrl_pkg::HTRANS_NSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    rv = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge hclk);
    rd(cpu_ctrl_pkg::REG_CMD);
    while (rv[2:0] !== 3'h0 && n < 50) begin
      rd(cpu_ctrl_pkg::REG_CMD);
      n++;
    end
    if (n >= 50) chk(rv, 32'h0, "sequencer stuck");
  endtask : wait_idle

  task automatic cmd(input logic [3:0] c, input logic [4:0] arg);
    wr(cpu_ctrl_pkg::REG_CMD, {23'h0, arg, c});
    wait_idle();
  endtask : cmd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    rd(a);
    chk(rv & m, e, s);
  endtask : rd_chk

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_total = 0;
    tests_run = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    wait_idle();
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, vec(16'h0000)}, "reset vector");
    rd_chk(cpu_ctrl_pkg::REG_STATUS, 32'hFF, 32'h02, "status reset");
    // Counter is read-only; unmapped place reads zero
    wr(cpu_ctrl_pkg::REG_PC, 32'h5555);
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, vec(16'h0000)}, "pc write ignored");
    wr(8'h24, 32'hFFFF_FFFF);
    rd_chk(8'h24, 32'hFFFF_FFFF, 32'h0, "unmapped read");
    chk({31'h0, hresp}, 32'h0, "bus response");
    // Stack must be loaded by software before use
    wr(cpu_ctrl_pkg::REG_SP, 32'hFEF0);
    rd_chk(cpu_ctrl_pkg::REG_SP, 32'hFFFF, 32'hFEF0, "sp load");
    cmd(cpu_ctrl_pkg::CMD_ADVANCE, 5'h03);
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, vec(16'h0000) + 16'h3}, "advance");
    wr(cpu_ctrl_pkg::REG_OPND, 32'h1234);
    cmd(cpu_ctrl_pkg::CMD_BRANCH, 5'h00);
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, 32'h1234, "branch");
    cmd(cpu_ctrl_pkg::CMD_TCALL, 5'h05);
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, vec(16'h004A)}, "table call");
    for (int i = 0; i < 9; i++) begin
      wr(cpu_ctrl_pkg::REG_OPND, {16'h0, ops[i].b, ops[i].a});
      cmd(ops[i].c, ops[i].arg);
      rd(cpu_ctrl_pkg::REG_STATUS);
      chk({29'h0, {rv[6], rv[4], rv[0]} & ops[i].m}, {29'h0, ops[i].f}, "flags");
      if (ops[i].c == cpu_ctrl_pkg::CMD_ADD || ops[i].c == cpu_ctrl_pkg::CMD_SUB)
        rd_chk(cpu_ctrl_pkg::REG_RESULT, 32'hFF, {24'h0, ops[i].r}, "alu result");
    end
    // Interrupt gating: enable flag, then per-source mask
    wr(cpu_ctrl_pkg::REG_SP, 32'hFEF0);
    rd(cpu_ctrl_pkg::REG_PC);
    pc_keep = rv[15:0];
    cmd(cpu_ctrl_pkg::CMD_DI, 5'h00);
    rd_chk(cpu_ctrl_pkg::REG_STATUS, 32'h80, 32'h00, "di clears ie");
    wr(cpu_ctrl_pkg::REG_MASK, 32'h7FF);
    wr(cpu_ctrl_pkg::REG_IRQ, 32'h004);
    wait_idle();
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, pc_keep}, "refused with ie clear");
    wr(cpu_ctrl_pkg::REG_MASK, 32'h000);
    cmd(cpu_ctrl_pkg::CMD_EI, 5'h00);
    rd_chk(cpu_ctrl_pkg::REG_STATUS, 32'h80, 32'h80, "ei sets ie");
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, pc_keep}, "refused when masked");
    wr(cpu_ctrl_pkg::REG_MASK, 32'h004);
    wait_idle();
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, vec(16'h0008)}, "irq vector");
    rd_chk(cpu_ctrl_pkg::REG_STATUS, 32'h80, 32'h00, "ack clears ie");
    rd_chk(cpu_ctrl_pkg::REG_SP, 32'hFFFF, 32'hFEED, "three bytes saved");
    cmd(cpu_ctrl_pkg::CMD_RETURN_FROM_IRQ_INSTRUCTION, 5'h00);
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, pc_keep}, "return address");
    rd_chk(cpu_ctrl_pkg::REG_STATUS, 32'h80, 32'h80, "status restored");
    rd_chk(cpu_ctrl_pkg::REG_SP, 32'hFFFF, 32'hFEF0, "sp after restore");
    // Explicit status save, change, restore
    rd(cpu_ctrl_pkg::REG_PC);
    pc_keep = rv[15:0];
    cmd(cpu_ctrl_pkg::CMD_PUSH_ST, 5'h00);
    rd_chk(cpu_ctrl_pkg::REG_SP, 32'hFFFF, 32'hFEED, "push status");
    cmd(cpu_ctrl_pkg::CMD_DI, 5'h00);
    cmd(cpu_ctrl_pkg::CMD_RETURN_FROM_IRQ_INSTRUCTION, 5'h00);
    rd_chk(cpu_ctrl_pkg::REG_STATUS, 32'h80, 32'h80, "status popped");
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, pc_keep}, "frame pc");
    rd_chk(cpu_ctrl_pkg::REG_SP, 32'hFFFF, 32'hFEF0, "sp popped");
    for (int i = 0; i < 11; i++) begin
      wr(cpu_ctrl_pkg::REG_ACCESS, {16'h0, rg_a[i]});
      rd_chk(cpu_ctrl_pkg::REG_ACCESS, 32'h7_0000, {13'h0, rg_e[i], 16'h0}, "region");
      chk({31'h0, sfr_sel}, {31'h0, rg_e[i] == 3'h4}, "peripheral select");
    end
    // Stack outside internal RAM raises the sticky flag
    wr(cpu_ctrl_pkg::REG_SP, 32'h1000);
    cmd(cpu_ctrl_pkg::CMD_PUSH_ST, 5'h00);
    rd_chk(cpu_ctrl_pkg::REG_SP, 32'h1_0000, 32'h1_0000, "stack outside ram");
    // Second reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    wait_idle();
    rd_chk(cpu_ctrl_pkg::REG_STATUS, 32'hFF, 32'h02, "status second reset");
    rd_chk(cpu_ctrl_pkg::REG_PC, 32'hFFFF, {16'h0, vec(16'h0000)}, "pc second reset");
    results();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    $display("MISMATCH t=%0t watchdog expired", $time);
    err_total++;
    results();
  end
endmodule : cpu_control_state_and_memory_map_tb
`default_nettype wire
